/* File: logic/uic_defs.svh */
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH
// Notes on behaviour
// - Writing one to bit 7 clears framing error
// - Writing one to bit 6 clears receive timeout
// - Writing one to bit 5 clears transmit interrupt
// - Writing one to bit 4 clears receive interrupt
// - Zero writes change nothing; clear bits reset zero
// - Clear register bits 3:0 read zero
// - Ident byte zero at 0xFD0, upper zero
// - Ident byte one at 0xFD4, upper zero
// - Ident values fixed, writes ignored, reset-stable
// - Clear removes raw and masked status together
// - Clear register sits at offset 0x044

// Address and data widths
`define UIC_ADDR_W    12
`define UIC_DATA_W    32

// Register byte offsets
`define UIC_OFS_MASK  12'h038
`define UIC_OFS_RAW   12'h03C
`define UIC_OFS_MIS   12'h040
`define UIC_OFS_ICR   12'h044
`define UIC_OFS_ID4   12'hFD0
`define UIC_OFS_ID5   12'hFD4

// Source field: bits 7:4, receive at bit 4
`define UIC_SRC_LSB   4
`define UIC_SRC_N     4
`define UIC_ID_W      8

// Reset values
`define UIC_RST_STAT  4'h0
`define UIC_RST_MASK  4'h0
`define UIC_RST_CLR   4'h0
`define UIC_RST_DATA  32'h0000_0000

// Identification bytes; values are arbitrary
`define UIC_ID_BYTE0  8'h3C
`define UIC_ID_BYTE1  8'hA5

`endif

/* File: logic/uic_pkg.sv */
`include "uic_defs.svh"

package uic_pkg;

    // APB request from the bus master
    typedef struct packed {
        logic                     psel;
        logic                     penable;
        logic                     pwrite;
        logic [`UIC_ADDR_W-1:0]   paddr;
        logic [`UIC_DATA_W-1:0]   pwdata;
        logic [3:0]               pstrb;
    } uic_apb_req_t;

    // APB answer to the bus master
    typedef struct packed {
        logic [`UIC_DATA_W-1:0]   prdata;
        logic                     pready;
        logic                     pslverr;
    } uic_apb_rsp_t;

    // One bit per interrupt source, same order as register bits 7:4
    typedef struct packed {
        logic framing_err;
        logic rx_timeout;
        logic transmit;
        logic receive;
    } uic_src_t;

    typedef enum logic [0:0] {
        PH_IDLE,
        PH_ACCESS
    } uic_phase_t;

    typedef struct packed {
        uic_phase_t               phase;
        logic [`UIC_SRC_N-1:0]    stat;
        logic [`UIC_SRC_N-1:0]    mask;
        logic [`UIC_SRC_N-1:0]    clr_pls;
        logic [`UIC_DATA_W-1:0]   rdata;
        logic                     slverr;
    } uic_state_t;

endpackage

/* File: logic/uic_regs.sv */
`include "uic_defs.svh"

module uic_regs #(
    parameter logic [`UIC_ID_W-1:0] ID_BYTE0 = `UIC_ID_BYTE0,
    parameter logic [`UIC_ID_W-1:0] ID_BYTE1 = `UIC_ID_BYTE1
) (
    // Clock and reset
    input  logic                  clk,
    input  logic                  sys_rst,
    // APB slave
    input  uic_pkg::uic_apb_req_t apb_req,
    output uic_pkg::uic_apb_rsp_t apb_rsp,
    // Interrupt events from the UART core
    input  uic_pkg::uic_src_t     src_event,
    // Clear strobes back to the UART core
    output uic_pkg::uic_src_t     src_clear,
    // Status views
    output uic_pkg::uic_src_t     raw_status,
    output uic_pkg::uic_src_t     masked_status,
    // Combined interrupt
    output logic                  irq
);
    import uic_pkg::*;

    localparam uic_state_t ST_RST = '{
        phase:   PH_IDLE,
        stat:    `UIC_RST_STAT,
        mask:    `UIC_RST_MASK,
        clr_pls: `UIC_RST_CLR,
        rdata:   `UIC_RST_DATA,
        slverr:  1'b0
    };

    uic_state_t              st_reg;
    uic_state_t              st_next;

    logic [`UIC_ADDR_W-1:0]  word_addr;
    logic                    setup_ph;
    logic                    access_ph;
    logic                    hit_mask;
    logic                    hit_raw;
    logic                    hit_mis;
    logic                    hit_icr;
    logic                    hit_id4;
    logic                    hit_id5;
    logic                    hit_any;
    logic                    wr_ok;
    logic                    lane0;
    logic [`UIC_SRC_N-1:0]   evt;
    logic [`UIC_SRC_N-1:0]   clr_hit;
    logic [`UIC_SRC_N-1:0]   stat_nx;

    // Word-aligned decode; byte offset bits are ignored
    assign word_addr = {apb_req.paddr[`UIC_ADDR_W-1:2], 2'b00};
    assign hit_mask  = (word_addr == `UIC_OFS_MASK);
    assign hit_raw   = (word_addr == `UIC_OFS_RAW);
    assign hit_mis   = (word_addr == `UIC_OFS_MIS);
    assign hit_icr   = (word_addr == `UIC_OFS_ICR);
    assign hit_id4   = (word_addr == `UIC_OFS_ID4);
    assign hit_id5   = (word_addr == `UIC_OFS_ID5);
    assign hit_any   = hit_mask | hit_raw | hit_mis | hit_icr | hit_id4 | hit_id5;

    assign setup_ph  = apb_req.psel & ~apb_req.penable;
    assign access_ph = apb_req.psel & apb_req.penable;
    assign lane0     = apb_req.pstrb[0];

    // A write acts only in a proper access phase to a mapped word
    assign wr_ok = access_ph & apb_req.pwrite & (st_reg.phase == PH_ACCESS) & ~st_reg.slverr;

    assign evt = src_event;

    // Per source: one in the clear field clears, zero leaves it; an event wins
    for (genvar gi = 0; gi < `UIC_SRC_N; gi++) begin : g_src
        assign clr_hit[gi] = wr_ok & lane0 & (hit_icr | hit_raw)
                             & apb_req.pwdata[`UIC_SRC_LSB + gi];
        assign stat_nx[gi] = (st_reg.stat[gi] & ~clr_hit[gi]) | evt[gi];
    end

    function automatic logic [`UIC_DATA_W-1:0] read_word(
        input logic [`UIC_ADDR_W-1:0] a,
        input uic_state_t             s
    );
        logic [`UIC_DATA_W-1:0] w;
        w = `UIC_RST_DATA;
        case (a)
            `UIC_OFS_MASK: w[`UIC_SRC_LSB +: `UIC_SRC_N] = s.mask;
            `UIC_OFS_RAW:  w[`UIC_SRC_LSB +: `UIC_SRC_N] = s.stat;
            `UIC_OFS_MIS:  w[`UIC_SRC_LSB +: `UIC_SRC_N] = s.stat & s.mask;
            `UIC_OFS_ICR:  w = `UIC_RST_DATA;
            `UIC_OFS_ID4:  w[`UIC_ID_W-1:0] = ID_BYTE0;
            `UIC_OFS_ID5:  w[`UIC_ID_W-1:0] = ID_BYTE1;
            default:       w = `UIC_RST_DATA;
        endcase
        return w;
    endfunction

    always_comb begin
        st_next         = st_reg;
        st_next.stat    = stat_nx;
        st_next.clr_pls = clr_hit;

        case (st_reg.phase)
            PH_IDLE: begin
                if (setup_ph) begin
                    st_next.phase = PH_ACCESS;
                end
            end
            PH_ACCESS: begin
                if (access_ph) begin
                    st_next.phase = PH_IDLE;
                end else if (!apb_req.psel) begin
                    st_next.phase = PH_IDLE;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase

        // Read data and error are settled in the setup cycle
        if (setup_ph) begin
            st_next.slverr = ~hit_any;
            if (apb_req.pwrite) begin
                st_next.rdata = `UIC_RST_DATA;
            end else begin
                st_next.rdata = read_word(word_addr, st_reg);
            end
        end

        // Ident words and masked status ignore writes
        if (wr_ok && lane0 && hit_mask) begin
            st_next.mask = apb_req.pwdata[`UIC_SRC_LSB +: `UIC_SRC_N];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Zero wait states; a stray access is answered with an error
    assign apb_rsp.pready  = access_ph;
    assign apb_rsp.pslverr = access_ph & ((st_reg.phase != PH_ACCESS) | st_reg.slverr);
    assign apb_rsp.prdata  = st_reg.rdata;

    assign src_clear     = st_reg.clr_pls;
    assign raw_status    = st_reg.stat;
    assign masked_status = st_reg.stat & st_reg.mask;
    assign irq           = |(st_reg.stat & st_reg.mask);

endmodule // uic_regs

/* File: testbench/uic_regs_checker.sv */
module uic_regs_checker #(
    parameter logic [7:0] ID_BYTE0 = 8'h00,
    parameter logic [7:0] ID_BYTE1 = 8'h00
) (
    input logic                  clk,
    input logic                  sys_rst,
    input uic_pkg::uic_apb_req_t apb_req,
    input uic_pkg::uic_apb_rsp_t apb_rsp,
    input uic_pkg::uic_src_t     src_event,
    input uic_pkg::uic_src_t     src_clear,
    input uic_pkg::uic_src_t     raw_status,
    input uic_pkg::uic_src_t     masked_status,
    input logic                  irq
);
    import uic_pkg::*;
    uic_apb_req_t q;
    assign q = apb_req;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence icr_wr;
        q.psel && !q.penable && q.pwrite && q.paddr[11:2] == 10'h011 ##1
        q.psel && q.penable && q.pstrb[0];
    endsequence
    sequence rd(logic [9:0] a);
        q.psel && !q.penable && !q.pwrite && q.paddr[11:2] == a ##1 q.psel && q.penable;
    endsequence
    chk_clear_pulse: assert property (icr_wr |=> src_clear == $past(q.pwdata[7:4]))
        else $error("clear pulse differs from written bits");
    chk_clear_status: assert property ((icr_wr ##0 src_event == 4'h0) |=>
        (raw_status & $past(q.pwdata[7:4])) == 4'h0)
        else $error("status bit survived a clear");
    chk_zero_keeps: assert property (icr_wr |=>
        (~raw_status & $past(raw_status) & ~$past(q.pwdata[7:4])) == 4'h0)
        else $error("zero write dropped a status bit");
    chk_irq_level: assert property (irq == |masked_status)
        else $error("irq does not follow masked status");
    chk_masked_sub: assert property ((masked_status & ~raw_status) == 4'h0)
        else $error("masked status without raw status");
    chk_icr_zero: assert property (rd(10'h011) |-> apb_rsp.prdata == 32'h0000_0000)
        else $error("clear register read not zero");
    chk_id_low: assert property (rd(10'h3F4) |-> apb_rsp.prdata == {24'h00_0000, ID_BYTE0})
        else $error("first ident read wrong");
    chk_id_high: assert property (rd(10'h3F5) |-> apb_rsp.prdata == {24'h00_0000, ID_BYTE1})
        else $error("second ident read wrong");
endmodule // uic_regs_checker

bind uic_regs uic_regs_checker #(.ID_BYTE0(ID_BYTE0), .ID_BYTE1(ID_BYTE1)) chk (.clk(clk),
    .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .src_event(src_event),
    .src_clear(src_clear), .raw_status(raw_status), .masked_status(masked_status), .irq(irq));

/* File: testbench/testbench.sv */
`include "uic_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import uic_pkg::*;
    logic         clk = 1'b0, sys_rst = 1'b1, irq, err;
    uic_apb_req_t req = '0;
    uic_apb_rsp_t rsp;
    uic_src_t     ev = '0, clr, raw, msk;
    logic [31:0]  rd;
    int           mismatches = 0, checks = 0;
    always #25 clk = ~clk;
    uic_regs dut (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .src_event(ev),
        .src_clear(clr), .raw_status(raw), .masked_status(msk), .irq(irq));
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(negedge clk);
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= '0;
        @(negedge clk);
    endtask
    task automatic t_ident;
        for (int k = 0; k < 2; k++) begin
            xfer(1'b1, 12'hFD0, 32'hFFFF_FFFF);
            `CHK("wr_err", 1'b0, err)
            xfer(1'b1, 12'hFD4, 32'hFFFF_FFFF);
            xfer(1'b0, 12'hFD0, 32'h0000_0000);
            `CHK("id0", {24'h00_0000, `UIC_ID_BYTE0}, rd)
            xfer(1'b0, 12'hFD4, 32'h0000_0000);
            `CHK("id1", {24'h00_0000, `UIC_ID_BYTE1}, rd)
            xfer(1'b0, 12'h044, 32'h0000_0000);
            `CHK("icr", 32'h0000_0000, rd)
            @(posedge clk);
            sys_rst <= 1'b1;
            repeat (2) @(posedge clk);
            sys_rst <= 1'b0;
            @(negedge clk);
        end
    endtask
    task automatic t_clears;
        for (int i = 0; i < 4; i++) begin
            pulse(4'hF);
            xfer(1'b1, 12'h044, 32'h0000_000F | (32'h0000_0010 << i));
            `CHK("raw", 4'hF & ~(4'h1 << i), raw)
            `CHK("clr", 4'h1 << i, clr)
        end
        xfer(1'b1, 12'h044, 32'h0000_00F0);
        `CHK("raw", 4'h0, raw)
        `CHK("clr", 4'hF, clr)
    endtask
    task automatic t_irq;
        xfer(1'b1, 12'h038, 32'h0000_0010);
        pulse(4'h3);
        `CHK("irq", 1'b1, irq)
        `CHK("mis", 4'h1, msk)
        xfer(1'b1, 12'h044, 32'h0000_0010);
        `CHK("irq", 1'b0, irq)
        `CHK("raw", 4'h2, raw)
        xfer(1'b0, 12'h100, 32'h0000_0000);
        `CHK("slverr", 1'b1, err)
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100_000;
        mismatches++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        t_ident;
        t_clears;
        t_irq;
        close_out;
    end
endmodule // testbench
